// [inc/gpc_pkg.sv]
package gpc_pkg;

  // Channel count and result widths
  localparam int unsigned NUM_CHAN     = 8;
  localparam int unsigned CHAN_W       = 3;
  localparam int unsigned COUNT_W      = 13;
  localparam int unsigned RESULT_W     = 16;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 13'h1FFF;
  localparam logic [COUNT_W-1:0] COUNT_RST = 13'h0000;

  // Timing reference and refresh figures
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned FRAME_HZ     = 90;
  localparam int unsigned SLOT_CYC_DEF = CLK_HZ / (FRAME_HZ * NUM_CHAN);
  localparam int unsigned DISCH_US     = 100;
  localparam int unsigned DISCH_CYC    = (DISCH_US * (CLK_HZ / 1_000_000) > 0) ?
                                         DISCH_US * (CLK_HZ / 1_000_000) : 1;
  localparam int unsigned SLOT_W       = 16;

  // Legacy register field positions
  localparam int unsigned LEG_AXIS_LSB = 0;
  localparam int unsigned LEG_BTN_LSB  = 4;
  localparam int unsigned LEG_FIELD_W  = 4;

  typedef enum logic [1:0] {
    GPC_DISCH,
    GPC_COUNT,
    GPC_IDLE
  } gpc_state_t;

  typedef struct packed {
    logic               analog;
    logic               pressed;
    logic [COUNT_W-1:0] count;
  } gpc_result_t;

  localparam gpc_result_t RESULT_RST = '{analog: 1'b0, pressed: 1'b0, count: COUNT_RST};

endpackage : gpc_pkg

// [design/gpc_capture.sv]
`timescale 1ns/1ps
module gpc_capture
  import gpc_pkg::*;
#(
  parameter int unsigned SLOT_CYC = SLOT_CYC_DEF
) (
  // Clock, reset, enable
  input  wire logic                mclk_i,
  input  wire logic                reset_n_i,
  input  wire logic                clk_en_i,
  // Game channel pins and timing capacitor
  input  wire logic [NUM_CHAN-1:0] game_channel_pins_i,
  input  wire logic                timing_cap_pos_i,
  output logic                     timing_cap_pos_o,
  output logic                     timing_cap_pos_oe_o,
  output logic [CHAN_W-1:0]        chan_sel_o,
  // Legacy polled port
  input  wire logic                legacy_wr_i,
  output logic [7:0]               legacy_rd_data_o,
  // High-precision port
  input  wire logic [CHAN_W-1:0]   hp_sel_i,
  output logic [RESULT_W-1:0]      hp_value_o,
  output logic [NUM_CHAN-1:0]      hp_is_analog_o
);

  // Pin synchronisers
  logic [NUM_CHAN-1:0] pin_m_r;
  logic [NUM_CHAN-1:0] pin_s_r;
  logic                cap_m_r;
  logic                cap_s_r;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pin_m_r <= '1;
      pin_s_r <= '1;
      cap_m_r <= 1'b0;
      cap_s_r <= 1'b0;
    end else if (clk_en_i) begin
      pin_m_r <= game_channel_pins_i;
      pin_s_r <= pin_m_r;
      cap_m_r <= timing_cap_pos_i;
      cap_s_r <= cap_m_r;
    end
  end

  // Capture sequencer
  gpc_state_t          state_r, state_nxt;
  logic [SLOT_W-1:0]   slot_r, slot_nxt;
  logic [COUNT_W-1:0]  cnt_r, cnt_nxt;
  logic [CHAN_W-1:0]   chan_r, chan_nxt;
  gpc_result_t         res_r [NUM_CHAN];
  gpc_result_t         res_nxt [NUM_CHAN];
  logic                slot_end;

  assign slot_end = (slot_r == SLOT_W'(SLOT_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    slot_nxt  = slot_end ? '0 : slot_r + 1'b1;
    cnt_nxt   = cnt_r;
    chan_nxt  = chan_r;
    res_nxt   = res_r;
    case (state_r)
      GPC_DISCH: begin
        cnt_nxt = COUNT_RST;
        if (slot_r == SLOT_W'(DISCH_CYC - 1)) begin
          state_nxt = GPC_COUNT;
        end
      end
      GPC_COUNT: begin
        if (cap_s_r) begin
          res_nxt[chan_r].analog = 1'b1;
          res_nxt[chan_r].count  = cnt_r;
          state_nxt              = GPC_IDLE;
        end else if (cnt_r == COUNT_MAX) begin
          res_nxt[chan_r].analog  = 1'b0;
          res_nxt[chan_r].pressed = ~pin_s_r[chan_r];
          state_nxt               = GPC_IDLE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      GPC_IDLE: begin
        state_nxt = GPC_IDLE;
      end
      default: begin
        state_nxt = GPC_DISCH;
      end
    endcase
    if (slot_end) begin
      state_nxt = GPC_DISCH;
      chan_nxt  = chan_r + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_r <= GPC_DISCH;
      slot_r  <= '0;
      cnt_r   <= COUNT_RST;
      chan_r  <= '0;
      for (int i = 0; i < NUM_CHAN; i++) begin
        res_r[i] <= RESULT_RST;
      end
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      slot_r  <= slot_nxt;
      cnt_r   <= cnt_nxt;
      chan_r  <= chan_nxt;
      res_r   <= res_nxt;
    end
  end

  assign timing_cap_pos_o    = 1'b0;
  assign timing_cap_pos_oe_o = (state_r == GPC_DISCH);
  assign chan_sel_o          = chan_r;

  // Legacy one-shot timer and high-precision read
  logic                leg_act_r, leg_act_nxt;
  logic [COUNT_W-1:0]  leg_cnt_r, leg_cnt_nxt;
  logic [7:0]          leg_data_r, leg_data_nxt;
  logic [RESULT_W-1:0] hp_val_r, hp_val_nxt;
  logic [NUM_CHAN-1:0] hp_ana_r, hp_ana_nxt;

  always_comb begin
    leg_act_nxt = leg_act_r;
    leg_cnt_nxt = leg_cnt_r;
    if (legacy_wr_i) begin
      leg_act_nxt = 1'b1;
      leg_cnt_nxt = COUNT_RST;
    end else if (leg_act_r) begin
      if (leg_cnt_r == COUNT_MAX) begin
        leg_act_nxt = 1'b0;
      end else begin
        leg_cnt_nxt = leg_cnt_r + 1'b1;
      end
    end
    leg_data_nxt = 8'h00;
    for (int i = 0; i < LEG_FIELD_W; i++) begin
      leg_data_nxt[LEG_AXIS_LSB + i] = leg_act_r && (leg_cnt_r < res_r[i].count);
      leg_data_nxt[LEG_BTN_LSB + i]  = ~res_r[LEG_FIELD_W + i].pressed;
    end
    hp_val_nxt = {{(RESULT_W - COUNT_W){1'b0}}, res_r[hp_sel_i].count};
    for (int i = 0; i < NUM_CHAN; i++) begin
      hp_ana_nxt[i] = res_r[i].analog;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      leg_act_r  <= 1'b0;
      leg_cnt_r  <= COUNT_RST;
      leg_data_r <= 8'hF0;
      hp_val_r   <= '0;
      hp_ana_r   <= '0;
    end else if (clk_en_i) begin
      leg_act_r  <= leg_act_nxt;
      leg_cnt_r  <= leg_cnt_nxt;
      leg_data_r <= leg_data_nxt;
      hp_val_r   <= hp_val_nxt;
      hp_ana_r   <= hp_ana_nxt;
    end
  end

  assign legacy_rd_data_o = leg_data_r;
  assign hp_value_o       = hp_val_r;
  assign hp_is_analog_o   = hp_ana_r;

  a_disch_drive: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (slot_r < SLOT_W'(DISCH_CYC)) |-> (timing_cap_pos_oe_o && !timing_cap_pos_o))
    else $error("capacitor not discharged");

  a_count_sat: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == GPC_COUNT && cnt_r == COUNT_MAX && !slot_end)
    |=> (state_r == GPC_IDLE && cnt_r == COUNT_MAX))
    else $error("count did not stop at maximum");

  a_trip_analog: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == GPC_COUNT && cap_s_r && !slot_end)
    |=> (res_r[chan_r].analog && res_r[chan_r].count == $past(cnt_r)))
    else $error("trip not stored as analog count");

  a_timeout_dig: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == GPC_COUNT && !cap_s_r && cnt_r == COUNT_MAX && !slot_end)
    |=> !res_r[chan_r].analog)
    else $error("timeout not marked digital");

  a_press_level: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == GPC_COUNT && !cap_s_r && cnt_r == COUNT_MAX && !slot_end)
    |=> (res_r[chan_r].pressed == !$past(pin_s_r[chan_r])))
    else $error("switch level wrong");

  a_chan_next: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (clk_en_i && slot_end) |=> (chan_r == CHAN_W'($past(chan_r) + 1) && state_r == GPC_DISCH))
    else $error("channel did not advance");

  a_slot_bound: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    slot_r < SLOT_W'(SLOT_CYC))
    else $error("slot counter out of range");

  a_hp_value: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    clk_en_i |=> (hp_value_o[RESULT_W-1:COUNT_W] == '0 &&
                  hp_value_o[COUNT_W-1:0] == $past(res_r[hp_sel_i].count)))
    else $error("result value or upper bits wrong");

  a_leg_start: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (clk_en_i && legacy_wr_i) |=> (leg_act_r && leg_cnt_r == COUNT_RST))
    else $error("legacy one-shot not started");

endmodule : gpc_capture

// [dv/gpc_far_side.sv]
`timescale 1ns/1ps
module gpc_far_side
  import gpc_pkg::*;
(
  // Design side
  input  wire logic                mclk_i,
  input  wire logic [CHAN_W-1:0]   chan_sel_i,
  input  wire logic                cap_drive_i,
  input  wire logic                cap_oe_i,
  // Peripheral setup
  input  wire logic [NUM_CHAN-1:0] analog_i,
  input  wire logic [NUM_CHAN-1:0] pressed_i,
  input  wire logic [COUNT_W-1:0]  charge_cyc_i [NUM_CHAN],
  // Pins
  output logic [NUM_CHAN-1:0]      pins_o,
  output logic                     cap_level_o
);
  logic [15:0] charge_r;

  // Cycles since the capacitor was released
  always_ff @(posedge mclk_i) begin
    if (cap_oe_i && !cap_drive_i) charge_r <= 16'h0000;
    else if (charge_r != 16'hFFFF) charge_r <= charge_r + 16'h0001;
  end

  assign pins_o = analog_i | ~pressed_i;
  // only a potentiometer charges the cap
  assign cap_level_o = analog_i[chan_sel_i] && !cap_oe_i &&
                       (charge_r >= {3'h0, charge_cyc_i[chan_sel_i]});
endmodule : gpc_far_side

// [dv/game_port_capture_tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  err_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module game_port_capture_tb_top
  import gpc_pkg::*;
;
  localparam int unsigned SLOT = 10300;
  logic                mclk = 1'b0;
  logic                reset_n = 1'b0;
  logic                clk_en = 1'b1;
  logic                legacy_wr = 1'b0;
  logic [CHAN_W-1:0]   hp_sel = '0;
  logic [NUM_CHAN-1:0] pins, analog, pressed;
  logic                cap_lvl, cap_drv, cap_oe;
  logic [CHAN_W-1:0]   chan_sel;
  logic [7:0]          leg_data;
  logic [RESULT_W-1:0] hp_value;
  logic [NUM_CHAN-1:0] hp_analog;
  logic [COUNT_W-1:0]  charge [NUM_CHAN];
  int                  err_count = 0;
  int                  num_checks = 0;
  int                  cyc = 0;
  integer              seed = 74;

  always #25 mclk = ~mclk;

  gpc_capture #(.SLOT_CYC(SLOT)) uut (
    .mclk_i(mclk), .reset_n_i(reset_n), .clk_en_i(clk_en),
    .game_channel_pins_i(pins), .timing_cap_pos_i(cap_lvl),
    .timing_cap_pos_o(cap_drv), .timing_cap_pos_oe_o(cap_oe), .chan_sel_o(chan_sel),
    .legacy_wr_i(legacy_wr), .legacy_rd_data_o(leg_data),
    .hp_sel_i(hp_sel), .hp_value_o(hp_value), .hp_is_analog_o(hp_analog));

  gpc_far_side far (
    .mclk_i(mclk), .chan_sel_i(chan_sel), .cap_drive_i(cap_drv), .cap_oe_i(cap_oe),
    .analog_i(analog), .pressed_i(pressed), .charge_cyc_i(charge),
    .pins_o(pins), .cap_level_o(cap_lvl));

  // Charge time plus synchroniser slack, upper bits clear
  function automatic logic cnt_ok(input logic [15:0] v, input logic [12:0] k);
    return v[15:13] == 3'h0 && v[12:0] >= k && v[12:0] <= k + 13'h0006;
  endfunction : cnt_ok

  task automatic summarize();
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 99000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      analog[i]  = $random(seed);
      pressed[i] = $random(seed);
      charge[i]  = 13'h0014 + 13'($unsigned($random(seed)) % 6000);
    end
    {analog[0], charge[0]} = {1'b1, 13'h0014};
    {analog[5], charge[5]} = {1'b1, 13'h1F40};
    {analog[6], pressed[6]} = 2'b00;
    {analog[7], pressed[7]} = 2'b01;
    repeat (20) @(negedge mclk);
    reset_n = 1'b1;
    `CHK("legacy_rst", 8'hF0, leg_data)
    `CHK("hp_rst", 16'h0000, hp_value)
    `CHK("oe_rst", 1'b1, cap_oe)
    for (int n = 0; n < NUM_CHAN; n++) begin
      repeat (SLOT / 2) @(negedge mclk);
      `CHK("chan_sel", 3'(n), chan_sel)
      repeat (SLOT - SLOT / 2) @(negedge mclk);
    end
    `CHK("is_analog", analog, hp_analog)
    for (int n = 0; n < NUM_CHAN; n++) begin
      hp_sel = 3'(n);
      @(negedge mclk);
      if (analog[n]) `CHK("hp_count", 1'b1, cnt_ok(hp_value, charge[n]))
      else `CHK("hp_digital", 16'h0000, hp_value)
    end
    legacy_wr = 1'b1;
    @(negedge mclk);
    legacy_wr = 1'b0;
    repeat (6) @(negedge mclk);
    `CHK("legacy_axis", analog[3:0], leg_data[3:0])
    `CHK("legacy_btn", analog[7:4] | ~pressed[7:4], leg_data[7:4])
    // Frozen one-shot must not run out while enable is low
    clk_en = 1'b0;
    repeat (40) @(negedge mclk);
    clk_en = 1'b1;
    repeat (5) @(negedge mclk);
    `CHK("legacy_freeze", analog[3:0], leg_data[3:0])
    repeat (8300) @(negedge mclk);
    `CHK("legacy_done", 4'h0, leg_data[3:0])
    summarize();
  end
endmodule : game_port_capture_tb_top
